//--- hdl/asp_port.sv
// Serial command and result port of the converter, with conversion sequencer
`timescale 1ns/10ps
module asp_port (
  input  wire logic                     ref_clk,            // System clock, 10 MHz
  input  wire logic                     arst_n,             // Async reset, active low
  input  wire logic                     sel_n_pin,          // Device select, active low
  input  wire logic                     sclk_pin,           // Serial bit clock
  input  wire logic                     serial_in_pin,      // Command data in
  input  wire logic                     program_enable_low, // Low allows programming
  input  wire logic                     conversion_clock,   // Conversion timing clock
  input  wire logic [asp_pkg::RES_W-1:0] analog_code,       // Digitised sample value
  output logic                          serial_out_pin,     // Result data out
  output logic                          serial_out_oe,      // Result pin driver enable
  output logic                          output_ready_flag,  // Low while shifting out
  output logic                          conversion_done,    // Low while busy
  output logic [3:0]                    channel_sel,        // Active mux channel
  output logic [3:0]                    program_enable_low_mode           // Active operating mode
);
  import asp_pkg::*;

  logic [4:0]       meta_r;
  logic [4:0]       sync_r;
  logic [4:0]       prev_r;
  logic             sel;
  logic             sel_fall;
  logic             sel_rise;
  logic             sclk_rise;
  logic             sclk_fall;
  logic             conversion_clock_rise;
  logic             din;
  logic             prog_n;
  logic [4:0]       clk_cnt_r;
  logic [4:0]       word_len_r;
  logic [CMD_W-1:0] cmd_r;
  logic [CMD_W-1:0] cmd_nxt;
  logic             seq_end;
  logic             program_enable_low_start;
  asp_program_enable_low_t        program_enable_low_st_r;
  logic [4:0]       step_r;
  logic [RES_W-1:0] sample_r;
  logic             done_prev_r;
  logic             done_rise;
  logic             load;
  logic [MAX_W-1:0] out_sr_r;
  logic             shifting_r;

  asp_fifo_if #(.W(RES_W)) res_if ();

  asp_fifo #(.W(RES_W), .DEPTH(FIFO_DEPTH)) u_fifo (
    .ref_clk (ref_clk),
    .arst_n  (arst_n),
    .port_if (res_if.fifo)
  );

  // Two-stage synchronisers for all asynchronous pins
  always_ff @(posedge ref_clk or negedge arst_n) begin
    if (!arst_n) begin
      meta_r <= 5'h09;
      sync_r <= 5'h09;
      prev_r <= 5'h09;
    end else begin
      meta_r <= {conversion_clock, program_enable_low, serial_in_pin, sclk_pin, sel_n_pin};
      sync_r <= meta_r;
      prev_r <= sync_r;
    end
  end

  assign sel       = ~sync_r[IX_SEL];
  assign sel_fall  = prev_r[IX_SEL] & ~sync_r[IX_SEL];
  assign sel_rise  = ~prev_r[IX_SEL] & sync_r[IX_SEL];
  assign sclk_rise = ~prev_r[IX_SCLK] & sync_r[IX_SCLK];
  assign sclk_fall = prev_r[IX_SCLK] & ~sync_r[IX_SCLK];
  assign conversion_clock_rise = ~prev_r[IX_CONVERSION_CLOCK] & sync_r[IX_CONVERSION_CLOCK];
  assign din       = sync_r[IX_DIN];
  assign prog_n    = sync_r[IX_PROG];

  // Command capture and pulse counting
  assign cmd_nxt = (clk_cnt_r < 5'(CMD_W)) ? {cmd_r[CMD_W-2:0], din} : cmd_r;
  assign seq_end = sel & sclk_rise & (clk_cnt_r == word_len_r - 5'h01);

  always_ff @(posedge ref_clk or negedge arst_n) begin
    if (!arst_n) begin
      clk_cnt_r <= '0;
      cmd_r     <= '0;
    end else if (sel_fall) begin
      clk_cnt_r <= '0;
    end else if (sel && sclk_rise) begin
      cmd_r     <= cmd_nxt;
      clk_cnt_r <= seq_end ? '0 : clk_cnt_r + 5'h01;
    end
  end

  // Configuration only changes while programming is enabled
  always_ff @(posedge ref_clk or negedge arst_n) begin
    if (!arst_n) begin
      word_len_r  <= DEF_WORD_LEN;
      channel_sel <= RST_CHANNEL;
      program_enable_low_mode   <= RST_MODE;
    end else if (seq_end && !prog_n) begin
      channel_sel <= cmd_nxt[3:0];
      program_enable_low_mode   <= cmd_nxt[7:4];
      if (cmd_nxt[7:4] == MODE_LEN17) begin
        word_len_r <= LONG_WORD_LEN;
      end else if (cmd_nxt[7:4] == MODE_LEN13) begin
        word_len_r <= DEF_WORD_LEN;
      end
    end
  end

  // Conversion sequencer stepped by conversion clock edges
  assign program_enable_low_start = !prog_n && (seq_end || (sel_fall && program_enable_low_st_r != CV_IDLE));
  assign res_if.wr_valid = (program_enable_low_st_r == CV_PUSH);
  assign res_if.wr_data  = sample_r;

  always_ff @(posedge ref_clk or negedge arst_n) begin
    if (!arst_n) begin
      program_enable_low_st_r <= CV_IDLE;
      step_r    <= '0;
      sample_r  <= '0;
    end else if (program_enable_low_start) begin
      program_enable_low_st_r <= CV_ACQ;
      step_r    <= '0;
    end else begin
      case (program_enable_low_st_r)
        CV_IDLE: begin
          step_r <= '0;
        end
        CV_ACQ: begin
          if (conversion_clock_rise) begin
            step_r <= (step_r == ACQ_CONVERSION_CLOCK - 5'h01) ? '0 : step_r + 5'h01;
            if (step_r == ACQ_CONVERSION_CLOCK - 5'h01) begin
              program_enable_low_st_r <= CV_SAR;
              sample_r  <= analog_code;
            end
          end
        end
        CV_SAR: begin
          if (conversion_clock_rise) begin
            step_r <= step_r + 5'h01;
            if (step_r == SAR_CONVERSION_CLOCK - 5'h01) begin
              program_enable_low_st_r <= CV_PUSH;
            end
          end
        end
        CV_PUSH: begin
          // Holds here while the FIFO is full
          if (res_if.wr_ready) begin
            program_enable_low_st_r <= CV_IDLE;
          end
        end
        default: begin
          program_enable_low_st_r <= CV_IDLE;
        end
      endcase
    end
  end

  always_ff @(posedge ref_clk or negedge arst_n) begin
    if (!arst_n) begin
      conversion_done <= 1'b1;
      done_prev_r     <= 1'b1;
    end else begin
      conversion_done <= (program_enable_low_st_r == CV_IDLE) && !program_enable_low_start;
      done_prev_r     <= conversion_done;
    end
  end

  // Result shift-out
  assign done_rise       = conversion_done & ~done_prev_r;
  assign load            = sel_fall || (sel && done_rise && !shifting_r);
  assign res_if.rd_ready = load;

  always_ff @(posedge ref_clk or negedge arst_n) begin
    if (!arst_n) begin
      out_sr_r       <= '0;
      serial_out_pin <= 1'b0;
    end else if (load) begin
      out_sr_r       <= {res_if.rd_data, {(MAX_W-RES_W){1'b0}}};
      serial_out_pin <= res_if.rd_data[RES_W-1];
    end else if (sel && sclk_fall && shifting_r) begin
      out_sr_r       <= {out_sr_r[MAX_W-2:0], 1'b0};
      serial_out_pin <= out_sr_r[MAX_W-2];
    end
  end

  always_ff @(posedge ref_clk or negedge arst_n) begin
    if (!arst_n) begin
      shifting_r        <= 1'b0;
      output_ready_flag <= 1'b1;
    end else if (load) begin
      shifting_r        <= 1'b1;
      output_ready_flag <= 1'b0;
    end else if (seq_end || sel_rise) begin
      shifting_r        <= 1'b0;
      output_ready_flag <= 1'b1;
    end
  end

  always_ff @(posedge ref_clk or negedge arst_n) begin
    if (!arst_n) begin
      serial_out_oe <= 1'b0;
    end else if (!sel) begin
      serial_out_oe <= 1'b0;
    end else if (sclk_rise) begin
      serial_out_oe <= 1'b1;
    end
  end

  sequence sel_clock_s;
    sel && sclk_rise;
  endsequence

  sequence seq_close_s;
    seq_end ##1 output_ready_flag;
  endsequence

  shift_in_a: assert property (@(posedge ref_clk) disable iff (!arst_n)
    sel_clock_s and (clk_cnt_r < 5'h08) && !sel_fall |=> cmd_r[0] == $past(din))
    else $error("Serial input bit not captured");
  out_enable_a: assert property (@(posedge ref_clk) disable iff (!arst_n)
    sel_clock_s |=> serial_out_oe [*1] ##1 (serial_out_oe || !sel))
    else $error("Output driver not enabled while selected");
  shift_out_a: assert property (@(posedge ref_clk) disable iff (!arst_n)
    sel && sclk_fall && shifting_r && !load |=> serial_out_pin == $past(out_sr_r[MAX_W-2]))
    else $error("Result bit not advanced on clock fall");
  sel_first_a: assert property (@(posedge ref_clk) disable iff (!arst_n)
    sel_fall |=> serial_out_pin == $past(res_if.rd_data[RES_W-1]) && !output_ready_flag)
    else $error("First bit not presented at select fall");
  done_first_a: assert property (@(posedge ref_clk) disable iff (!arst_n)
    sel && done_rise && !shifting_r |=> !output_ready_flag)
    else $error("First bit not presented at done rise");
  abort_restart_a: assert property (@(posedge ref_clk) disable iff (!arst_n)
    sel_fall && program_enable_low_st_r != CV_IDLE && !prog_n |=> program_enable_low_st_r == CV_ACQ && !conversion_done)
    else $error("Conversion not restarted on select fall");
  ready_high_a: assert property (@(posedge ref_clk) disable iff (!arst_n)
    seq_end && !load |-> seq_close_s)
    else $error("Ready not raised after last bit");
  prog_hold_a: assert property (@(posedge ref_clk) disable iff (!arst_n)
    prog_n |=> $stable(channel_sel) && $stable(program_enable_low_mode) && $stable(word_len_r))
    else $error("Configuration changed in read-only mode");
  busy_low_a: assert property (@(posedge ref_clk) disable iff (!arst_n)
    program_enable_low_st_r != CV_IDLE |=> !conversion_done)
    else $error("Done high while converting");
  len_legal_a: assert property (@(posedge ref_clk) disable iff (!arst_n)
    word_len_r == DEF_WORD_LEN || word_len_r == LONG_WORD_LEN)
    else $error("Illegal word length");
endmodule

//--- hdl/asp_pkg.sv
// Constants shared by the serial converter port and its result FIFO
package asp_pkg;
  localparam int       RES_W        = 13;
  localparam int       MAX_W        = 17;
  localparam int       CMD_W        = 8;
  localparam int       FIFO_DEPTH   = 4;
  localparam logic [4:0] DEF_WORD_LEN  = 5'h0d;
  localparam logic [4:0] LONG_WORD_LEN = 5'h11;
  localparam logic [4:0] ACQ_CONVERSION_CLOCK      = 5'h06;
  localparam logic [4:0] SAR_CONVERSION_CLOCK      = 5'h0d;
  localparam logic [3:0] MODE_LEN13    = 4'h1;
  localparam logic [3:0] MODE_LEN17    = 4'h2;
  localparam logic [3:0] RST_CHANNEL   = 4'h0;
  localparam logic [3:0] RST_MODE      = 4'h0;
  // Synchronised input positions
  localparam int       IX_SEL       = 0;
  localparam int       IX_SCLK      = 1;
  localparam int       IX_DIN       = 2;
  localparam int       IX_PROG      = 3;
  localparam int       IX_CONVERSION_CLOCK      = 4;
  typedef enum logic [1:0] {
    CV_IDLE = 2'b00,
    CV_ACQ  = 2'b01,
    CV_SAR  = 2'b10,
    CV_PUSH = 2'b11
  } asp_program_enable_low_t;
endpackage

//--- hdl/asp_fifo_if.sv
// Valid/ready carrier between the converter core and the result FIFO
`timescale 1ns/10ps
interface asp_fifo_if #(parameter int W = 13);
  logic         wr_valid;
  logic         wr_ready;
  logic [W-1:0] wr_data;
  logic         rd_valid;
  logic         rd_ready;
  logic [W-1:0] rd_data;
  modport fifo (input wr_valid, wr_data, rd_ready, output wr_ready, rd_valid, rd_data);
  modport user (output wr_valid, wr_data, rd_ready, input wr_ready, rd_valid, rd_data);
endinterface

//--- hdl/asp_fifo.sv
// Small result FIFO with valid/ready on both sides
`timescale 1ns/10ps
module asp_fifo #(
  parameter int W     = 13,
  parameter int DEPTH = 4
) (
  input  wire logic ref_clk,  // System clock
  input  wire logic arst_n,   // Async reset, active low
  asp_fifo_if.fifo  port_if   // Write and read sides
);
  localparam int AW = $clog2(DEPTH);
  logic [W-1:0] mem_r [DEPTH];
  logic [AW-1:0] wptr_r;
  logic [AW-1:0] rptr_r;
  logic [AW:0]   cnt_r;
  logic          do_wr;
  logic          do_rd;

  assign port_if.wr_ready = (cnt_r != (AW+1)'(DEPTH));
  assign port_if.rd_valid = (cnt_r != '0);
  assign port_if.rd_data  = mem_r[rptr_r];
  assign do_wr = port_if.wr_valid & port_if.wr_ready;
  assign do_rd = port_if.rd_valid & port_if.rd_ready;

  // Cleared so that a read from an empty FIFO entry never yet written shifts zeros, not unknowns
  always_ff @(posedge ref_clk or negedge arst_n) begin
    if (!arst_n) begin
      for (int i = 0; i < DEPTH; i++) begin
        mem_r[i] <= '0;
      end
    end else if (do_wr) begin
      mem_r[wptr_r] <= port_if.wr_data;
    end
  end

  always_ff @(posedge ref_clk or negedge arst_n) begin
    if (!arst_n) begin
      wptr_r <= '0;
      rptr_r <= '0;
      cnt_r  <= '0;
    end else begin
      if (do_wr) begin
        wptr_r <= (wptr_r == AW'(DEPTH-1)) ? '0 : wptr_r + AW'(1);
      end
      if (do_rd) begin
        rptr_r <= (rptr_r == AW'(DEPTH-1)) ? '0 : rptr_r + AW'(1);
      end
      if (do_wr && !do_rd) begin
        cnt_r <= cnt_r + (AW+1)'(1);
      end else if (do_rd && !do_wr) begin
        cnt_r <= cnt_r - (AW+1)'(1);
      end
    end
  end
endmodule

//--- testbench/asp_host_model.sv
// Host serial master model driving the converter's serial port
`timescale 1ns/10ps
module asp_host_model (
  input  wire logic ref_clk,           // System clock
  output logic      sel_n_pin,         // Device select, active low
  output logic      sclk_pin,          // Serial bit clock
  output logic      serial_in_pin,     // Command data to device
  input  wire logic dout_wire,         // Resolved result line
  input  wire logic serial_out_oe,     // Result driver enable
  input  wire logic output_ready_flag  // Shift-out status
);
  initial begin
    sel_n_pin     = 1'b1;
    sclk_pin      = 1'b0;
    serial_in_pin = 1'b0;
  end
  // One whole sequence; bits are taken at each clock fall, after the device drives
  task automatic frame(input int n, input logic [7:0] cmd, output logic [16:0] res,
                       output logic rdy_mid, output logic rdy_end, output logic oe_mid,
                       output logic oe_end);
    res = 17'h00000;
    @(posedge ref_clk);
    #2;
    sel_n_pin = 1'b0;
    for (int i = 0; i < n; i++) begin
      serial_in_pin = (i < 8) ? cmd[7-i] : 1'b0;
      #400;
      sclk_pin = 1'b1;
      #400;
      res = {res[15:0], dout_wire};
      if (i == n - 2) begin
        rdy_mid = output_ready_flag;
        oe_mid  = serial_out_oe;
      end
      sclk_pin = 1'b0;
    end
    #400;
    rdy_end       = output_ready_flag;
    sel_n_pin     = 1'b1;
    serial_in_pin = ~serial_in_pin;
    #400;
    oe_end = serial_out_oe;
  endtask
  // Select level change only, with the serial clock resting low
  task automatic select(input logic on);
    @(posedge ref_clk);
    #2;
    sel_n_pin = ~on;
  endtask
  // Clock pulses without touching select; bits taken at each clock fall
  task automatic pulses(input int n, input logic [7:0] cmd, output logic [16:0] res);
    res = 17'h00000;
    for (int i = 0; i < n; i++) begin
      serial_in_pin = (i < 8) ? cmd[7-i] : 1'b0;
      #400;
      sclk_pin = 1'b1;
      #400;
      res = {res[15:0], dout_wire};
      sclk_pin = 1'b0;
    end
  endtask
endmodule

//--- testbench/tb_asp_port.sv
// Self-checking bench for the converter serial port
`timescale 1ns/10ps
module tb_asp_port;
  import asp_pkg::*;
  logic              ref_clk;
  logic              arst_n;
  logic              sel_n_pin;
  logic              sclk_pin;
  logic              serial_in_pin;
  logic              program_enable_low;
  logic              conversion_clock;
  logic [RES_W-1:0]  analog_code;
  logic              serial_out_pin;
  logic              serial_out_oe;
  logic              output_ready_flag;
  logic              conversion_done;
  logic [3:0]        channel_sel;
  logic [3:0]        program_enable_low_mode;
  logic              dout_last;
  logic              dout_wire;
  logic [16:0]       res;
  int                errors;
  int                n_checks;

  asp_port u_asp_port (
    .ref_clk(ref_clk), .arst_n(arst_n), .sel_n_pin(sel_n_pin), .sclk_pin(sclk_pin),
    .serial_in_pin(serial_in_pin), .program_enable_low(program_enable_low),
    .conversion_clock(conversion_clock), .analog_code(analog_code),
    .serial_out_pin(serial_out_pin), .serial_out_oe(serial_out_oe),
    .output_ready_flag(output_ready_flag), .conversion_done(conversion_done),
    .channel_sel(channel_sel), .program_enable_low_mode(program_enable_low_mode)
  );
  asp_host_model u_asp_host_model (
    .ref_clk(ref_clk), .sel_n_pin(sel_n_pin), .sclk_pin(sclk_pin),
    .serial_in_pin(serial_in_pin), .dout_wire(dout_wire), .serial_out_oe(serial_out_oe),
    .output_ready_flag(output_ready_flag)
  );

  // Undriven line shows the inverse of its last driven level
  always @(posedge ref_clk or negedge arst_n) begin
    if (!arst_n) begin
      dout_last <= 1'b0;
    end else if (serial_out_oe === 1'b1) begin
      dout_last <= serial_out_pin;
    end
  end
  assign dout_wire = (serial_out_oe === 1'b1) ? serial_out_pin : ~dout_last;

  initial begin
    ref_clk = 1'b0;
    forever #50 ref_clk = ~ref_clk;
  end
  initial begin
    conversion_clock = 1'b0;
    forever #300 conversion_clock = ~conversion_clock;
  end

  task automatic check(input string name, input logic [16:0] seen, input logic [16:0] exp);
    n_checks++;
    if (seen !== exp) begin
      errors++;
      $display("ERROR %s expected %h seen %h", name, exp, seen);
    end
  endtask

  task automatic print_verdict();
    if (errors == 0 && n_checks > 0) begin
      $display("Test passed");
    end else begin
      $display("Test failed");
    end
    $finish;
  endtask

  task automatic wait_done();
    int k;
    for (k = 0; k < 600 && conversion_done !== 1'b1; k++) begin
      @(posedge ref_clk);
      #2;
    end
    if (k == 600) begin
      errors++;
      $display("ERROR conversion_done expected 1 seen timeout");
      print_verdict();
    end
  endtask

  // Runs a sequence and judges the status lines around it
  task automatic do_frame(input int n, input logic [7:0] cmd);
    logic rm;
    logic re;
    logic om;
    logic oe;
    u_asp_host_model.frame(n, cmd, res, rm, re, om, oe);
    check("ready_mid", {16'h0000, rm}, 17'h00000);
    check("ready_end", {16'h0000, re}, 17'h00001);
    check("oe_mid", {16'h0000, om}, 17'h00001);
    check("oe_end", {16'h0000, oe}, 17'h00000);
  endtask

  task automatic s_basic();
    do_frame(13, 8'h15);
    check("channel", {13'h0000, channel_sel}, 17'h00005);
    check("mode", {13'h0000, program_enable_low_mode}, 17'h00001);
    check("done_busy", {16'h0000, conversion_done}, 17'h00000);
    wait_done();
  endtask

  task automatic s_read_long();
    analog_code = 13'h0abc;
    do_frame(13, 8'h23);
    check("result13", res, {4'h0, 13'h15a3});
    wait_done();
    analog_code = 13'h1e01;
    do_frame(17, 8'h13);
    check("result17", res, {13'h0abc, 4'h0});
    check("channel", {13'h0000, channel_sel}, 17'h00003);
    wait_done();
  endtask

  task automatic s_readonly();
    program_enable_low = 1'b1;
    do_frame(13, 8'h29);
    check("ro_result", res, {4'h0, 13'h1e01});
    check("ro_channel", {13'h0000, channel_sel}, 17'h00003);
    check("ro_mode", {13'h0000, program_enable_low_mode}, 17'h00001);
    check("ro_done", {16'h0000, conversion_done}, 17'h00001);
    program_enable_low = 1'b0;
  endtask

  task automatic s_abort();
    analog_code = 13'h0777;
    do_frame(13, 8'h17);
    repeat (20) @(posedge ref_clk);
    #2;
    check("mid_program_enable_low", {16'h0000, conversion_done}, 17'h00000);
    // Without the abort the first conversion would end inside this frame
    fork
      do_frame(13, 8'h18);
      begin
        repeat (100) @(posedge ref_clk);
        #2;
        check("restart_mid", {16'h0000, conversion_done}, 17'h00000);
      end
    join
    check("restart", {16'h0000, conversion_done}, 17'h00000);
    wait_done();
    check("ab_channel", {13'h0000, channel_sel}, 17'h00008);
    program_enable_low = 1'b1;
    do_frame(13, 8'h00);
    check("ab_result", res, {4'h0, 13'h0777});
  endtask

  // Select held low: first result bit comes with the end of conversion
  task automatic s_held();
    logic [16:0] r;
    program_enable_low = 1'b0;
    analog_code        = 13'h0f0f;
    u_asp_host_model.select(1'b1);
    u_asp_host_model.pulses(13, 8'h12, r);
    wait_done();
    repeat (2) @(posedge ref_clk);
    #2;
    check("held_ready", {16'h0000, output_ready_flag}, 17'h00000);
    u_asp_host_model.pulses(13, 8'h12, r);
    check("held_result", r, {4'h0, 13'h0f0f});
    check("held_channel", {13'h0000, channel_sel}, 17'h00002);
    check("held_end", {16'h0000, output_ready_flag}, 17'h00001);
    u_asp_host_model.select(1'b0);
    wait_done();
  endtask

  initial begin
    errors             = 0;
    n_checks           = 0;
    arst_n             = 1'b0;
    program_enable_low = 1'b0;
    analog_code        = 13'h15a3;
    repeat (3) @(posedge ref_clk);
    #2;
    arst_n = 1'b1;
    repeat (3) @(posedge ref_clk);
    s_basic();
    s_read_long();
    s_readonly();
    s_abort();
    s_held();
    print_verdict();
  end
endmodule
